// ===== verilog/csf_pkg.sv
// Package with addresses, bit positions and reset values of the core SFRs
package csf_pkg;
  // Data memory map
  localparam logic [7:0] ADDR_INDIRECT  = 8'h00;
  localparam logic [7:0] ADDR_MPTR      = 8'h01;
  localparam logic [7:0] ADDR_ACC       = 8'h05;
  localparam logic [7:0] ADDR_PCL       = 8'h06;
  localparam logic [7:0] ADDR_TBL_PTR   = 8'h07;
  localparam logic [7:0] ADDR_TBL_HIGH  = 8'h08;
  localparam logic [7:0] ADDR_FLAGS     = 8'h0a;
  localparam logic [7:0] ADDR_GAP_FIRST = 8'h28;
  localparam logic [7:0] ADDR_SPC_LAST  = 8'h3f;
  localparam logic [7:0] ADDR_GP_FIRST  = 8'h40;
  localparam logic [7:0] ADDR_GP_LAST   = 8'h5f;
  localparam int         GP_DEPTH       = 32;
  // Flag bit positions
  localparam int BIT_WDT  = 5;
  localparam int BIT_PDN  = 4;
  localparam int BIT_OV   = 3;
  localparam int BIT_Z    = 2;
  localparam int BIT_AC   = 1;
  localparam int BIT_C    = 0;
  // Values after reset
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [3:0] RST_ARITH = 4'h0;
  // Table word: 14 bits, upper 6 go to the table high byte
  localparam int TBL_WORD_W = 14;
  // ALU operation classes seen by the flag unit
  typedef enum logic [2:0] {
    CSF_OP_ADD,
    CSF_OP_SUB,
    CSF_OP_LOGIC,
    CSF_OP_RLC,
    CSF_OP_RRC
  } csf_op_e;
endpackage

// ===== verilog/csf_flag_unit.sv
// Combinational ALU result and flag generation for the core flags
`timescale 1ns/1ps
module csf_flag_unit
  import csf_pkg::*;
(
  input  wire csf_op_e    i_op,      // Operation class
  input  wire logic [7:0] i_a,       // First operand
  input  wire logic [7:0] i_b,       // Second operand or logic result
  input  wire logic       i_cin,     // Current carry flag
  output logic      [7:0] o_result,  // Value for the accumulator
  output logic      [3:0] o_flags,   // {ov, z, ac, c}
  output logic      [3:0] o_update   // Which of the four flags change
);
  // Subtraction is a + ~b + 1, so carry out means no borrow
  wire logic [7:0] b_eff   = (i_op == CSF_OP_SUB) ? ~i_b : i_b;
  wire logic       c_first = (i_op == CSF_OP_SUB);
  wire logic [4:0] lo_sum  = {1'b0, i_a[3:0]} + {1'b0, b_eff[3:0]}
                             + {4'h0, c_first};
  wire logic [7:0] lo7_sum = {1'b0, i_a[6:0]} + {1'b0, b_eff[6:0]}
                             + {7'h00, c_first};
  wire logic [8:0] sum     = {1'b0, i_a} + {1'b0, b_eff}
                             + {8'h00, c_first};
  wire logic       arith   = (i_op == CSF_OP_ADD) || (i_op == CSF_OP_SUB);
  wire logic       rot     = (i_op == CSF_OP_RLC) || (i_op == CSF_OP_RRC);

  // Result selection
  assign o_result = arith ? sum[7:0] :
                    (i_op == CSF_OP_RLC) ? {i_a[6:0], i_cin} :
                    (i_op == CSF_OP_RRC) ? {i_cin, i_a[7:1]} : i_b;

  // Flags: ov from carry into vs out of bit 7
  assign o_flags[3] = lo7_sum[7] ^ sum[8];
  assign o_flags[2] = (o_result == 8'h00);
  assign o_flags[1] = lo_sum[4];
  assign o_flags[0] = arith ? sum[8] :
                      (i_op == CSF_OP_RLC) ? i_a[7] : i_a[0];

  // Rotates touch only carry; logic ops touch only zero
  assign o_update = arith ? 4'hf :
                    rot ? 4'h1 :
                    (i_op == CSF_OP_LOGIC) ? 4'h4 : 4'h0;
endmodule // csf_flag_unit

// ===== verilog/csf_core_regs.sv
// Core special function registers and general data memory
`timescale 1ns/1ps
module csf_core_regs
  import csf_pkg::*;
(
  input  wire logic       I_CLOCK,        // 40 MHz system clock
  input  wire logic       I_SRST,         // Sync reset, active high
  input  wire logic [7:0] I_ADDR,         // Data memory address
  input  wire logic       I_RD,           // Read strobe
  input  wire logic       I_WR,           // Write strobe
  input  wire logic [7:0] I_WDATA,        // Write data
  input  wire logic       I_ALU_VALID,    // ALU operation this cycle
  input  wire csf_op_e    I_ALU_OP,       // ALU operation class
  input  wire logic [7:0] I_ALU_B,        // Second operand / logic result
  input  wire logic       I_ACC_LOAD,     // Load accumulator from I_WDATA
  input  wire logic       I_TBL_VALID,    // Table word fetched
  input  wire logic [TBL_WORD_W-1:0] I_TBL_WORD, // Fetched table word
  input  wire logic       I_WDT_EXPIRY,   // Watchdog time-out event
  input  wire logic       I_DOG_KICK,     // Watchdog clear instruction
  input  wire logic       I_HALT,         // Halt instruction
  output logic      [7:0] O_RDATA,        // Read data, one cycle later
  output logic      [7:0] O_ACC,          // Accumulator
  output logic      [7:0] O_TBL_PTR,      // Table pointer to fetch unit
  output logic      [7:0] O_TBL_LOW,      // Low table byte for destination
  output logic      [7:0] O_FLAGS,        // Flag register image
  output logic            O_JUMP,         // Jump pulse after PROGRAM_COUNTER_LOW write
  output logic      [7:0] O_PC_LOW,       // New low program counter byte
  output logic            O_DUMMY_CYCLE   // Dummy cycle request
);
  // Decode helpers
  function automatic logic is_gp(input logic [7:0] a);
    is_gp = (a >= ADDR_GP_FIRST) && (a <= ADDR_GP_LAST);
  endfunction

  // State
  logic [7:0] ram_mem [GP_DEPTH];
  logic [7:0] mptr_reg;
  logic [7:0] acc_reg;
  logic [7:0] tbl_ptr_reg;
  logic [7:0] tbl_high_reg;
  logic [7:0] tbl_low_reg;
  logic [3:0] arith_reg;
  logic [3:0] arith_next;
  logic       wdt_reg;
  logic       wdt_next;
  logic       pdn_reg;
  logic       pdn_next;
  logic [7:0] rdata_reg;
  logic       jump_reg;
  logic [7:0] pc_low_reg;
  logic [7:0] alu_res;
  logic [3:0] alu_flags;
  logic [3:0] alu_upd;

  // Indirect access redirects to the pointer, bank 0 only
  wire logic       via_port = (I_ADDR == ADDR_INDIRECT);
  wire logic [7:0] eff_addr = via_port ? mptr_reg : I_ADDR;
  // Pointer aimed at the port itself: nothing stored there
  wire logic       no_store = (eff_addr == ADDR_INDIRECT);
  wire logic       wr_ok    = I_WR && !no_store;
  wire logic       wr_mptr  = wr_ok && (eff_addr == ADDR_MPTR);
  wire logic       wr_acc   = wr_ok && (eff_addr == ADDR_ACC);
  wire logic       wr_pcl   = wr_ok && (eff_addr == ADDR_PCL);
  wire logic       wr_tptr  = wr_ok && (eff_addr == ADDR_TBL_PTR);
  wire logic       wr_flags = wr_ok && (eff_addr == ADDR_FLAGS);
  wire logic       wr_gp    = wr_ok && is_gp(eff_addr);
  wire logic [4:0] gp_idx   = eff_addr[4:0];
  wire logic [7:0] flags_img = {2'h0, wdt_reg, pdn_reg, arith_reg};

  // Read mux; gaps and the port itself answer zero
  wire logic [7:0] rd_val =
    no_store                    ? RST_BYTE :
    is_gp(eff_addr)             ? ram_mem[gp_idx] :
    (eff_addr == ADDR_MPTR)     ? mptr_reg :
    (eff_addr == ADDR_ACC)      ? acc_reg :
    (eff_addr == ADDR_PCL)      ? pc_low_reg :
    (eff_addr == ADDR_TBL_PTR)  ? tbl_ptr_reg :
    (eff_addr == ADDR_TBL_HIGH) ? tbl_high_reg :
    (eff_addr == ADDR_FLAGS)    ? flags_img : RST_BYTE;

  // Flag computation lives in the leaf unit
  csf_flag_unit u_flags (
    .i_op     (I_ALU_OP),
    .i_a      (acc_reg),
    .i_b      (I_ALU_B),
    .i_cin    (arith_reg[BIT_C]),
    .o_result (alu_res),
    .o_flags  (alu_flags),
    .o_update (alu_upd)
  );

  // Arithmetic flags: bus write first, ALU update on top of it
  wire logic [3:0] arith_wr = wr_flags ? I_WDATA[3:0] : arith_reg;
  wire logic [3:0] alu_mask = I_ALU_VALID ? alu_upd : 4'h0;
  assign arith_next = (alu_flags & alu_mask) | (arith_wr & ~alu_mask);

  // System flags ignore bus writes; expiry set beats a clear
  assign wdt_next = I_WDT_EXPIRY ? 1'b1 :
                    (I_DOG_KICK || I_HALT) ? 1'b0 : wdt_reg;
  assign pdn_next = I_HALT ? 1'b1 :
                    I_DOG_KICK ? 1'b0 : pdn_reg;

  // General purpose RAM holds no reset; contents unknown at power-up
  always_ff @(posedge I_CLOCK) begin
    if (wr_gp) begin
      ram_mem[gp_idx] <= I_WDATA;
    end
  end

  // Memory pointer: a plain register, also reachable through the port
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      mptr_reg <= RST_BYTE;
    end else if (wr_mptr) begin
      mptr_reg <= I_WDATA;
    end
  end

  // Accumulator; the ALU wins so a result is never lost to a bus move
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      acc_reg <= RST_BYTE;
    end else if (I_ALU_VALID) begin
      acc_reg <= alu_res;
    end else if (I_ACC_LOAD || wr_acc) begin
      acc_reg <= I_WDATA;
    end
  end

  // Table pointer; stepping it is a read-modify-write over the bus
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      tbl_ptr_reg <= RST_BYTE;
    end else if (wr_tptr) begin
      tbl_ptr_reg <= I_WDATA;
    end
  end

  // Table high byte: read only, loaded by the fetch alone
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      tbl_high_reg <= RST_BYTE;
    end else if (I_TBL_VALID) begin
      tbl_high_reg <= {2'h0, I_TBL_WORD[TBL_WORD_W-1:8]};
    end
  end

  // Table low byte is handed back for the named destination
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      tbl_low_reg <= RST_BYTE;
    end else if (I_TBL_VALID) begin
      tbl_low_reg <= I_TBL_WORD[7:0];
    end
  end

  // Watchdog expiry flag; only reset, expiry, kick and halt move it
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      wdt_reg <= 1'h0;
    end else begin
      wdt_reg <= wdt_next;
    end
  end

  // Power-down flag; bus writes never reach it
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      pdn_reg <= 1'h0;
    end else begin
      pdn_reg <= pdn_next;
    end
  end

  // Arithmetic flags cleared too, though software may not rely on it
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      arith_reg <= RST_ARITH;
    end else begin
      arith_reg <= arith_next;
    end
  end

  // Jump pulse lasts one cycle; a second write restarts it
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      jump_reg <= 1'h0;
    end else begin
      jump_reg <= wr_pcl;
    end
  end

  // New low PC byte; the page bits stay with the fetch unit
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      pc_low_reg <= RST_BYTE;
    end else if (wr_pcl) begin
      pc_low_reg <= I_WDATA;
    end
  end

  // Registered read data holds until the next read
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      rdata_reg <= RST_BYTE;
    end else if (I_RD) begin
      rdata_reg <= rd_val;
    end
  end

  // No push of flags on calls: nothing here saves them
  assign O_RDATA       = rdata_reg;
  assign O_ACC         = acc_reg;
  assign O_TBL_PTR     = tbl_ptr_reg;
  assign O_TBL_LOW     = tbl_low_reg;
  assign O_FLAGS       = flags_img;
  assign O_JUMP        = jump_reg;
  assign O_PC_LOW      = pc_low_reg;
  assign O_DUMMY_CYCLE = jump_reg;

  // Checks
  wdt_set_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_WDT_EXPIRY |=> O_FLAGS[BIT_WDT])
    else $error("watchdog flag not set after expiry");
  wdt_clear_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    (I_HALT || I_DOG_KICK) && !I_WDT_EXPIRY |=> !O_FLAGS[BIT_WDT])
    else $error("watchdog flag not cleared");
  pdn_flag_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    (I_HALT |=> O_FLAGS[BIT_PDN]) and
    (I_DOG_KICK && !I_HALT |=> !O_FLAGS[BIT_PDN]))
    else $error("power-down flag wrong");
  sys_flag_hold_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    !I_HALT && !I_DOG_KICK && !I_WDT_EXPIRY
    |=> $stable(O_FLAGS[BIT_WDT:BIT_PDN]))
    else $error("system flags changed without cause");
  top_bits_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    O_FLAGS[7:6] == 2'b00)
    else $error("flag bits 7:6 not zero");
  pcl_jump_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_WR && I_ADDR == ADDR_PCL |=> O_JUMP && O_DUMMY_CYCLE
    && O_PC_LOW == $past(I_WDATA) ##1 !O_JUMP || $past(wr_pcl))
    else $error("low PC write did not jump once");
  port_zero_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_RD && via_port && mptr_reg == ADDR_INDIRECT |=> O_RDATA == 8'h00)
    else $error("indirect port read not zero");
  gap_zero_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_RD && eff_addr >= ADDR_GAP_FIRST && eff_addr <= ADDR_SPC_LAST
    |=> O_RDATA == 8'h00)
    else $error("unused location not zero");
  tbl_high_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_TBL_VALID |=> tbl_high_reg[5:0] == $past(I_TBL_WORD[13:8])
    && O_TBL_LOW == $past(I_TBL_WORD[7:0]))
    else $error("table bytes misplaced");
  zero_flag_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_ALU_VALID && I_ALU_OP == CSF_OP_LOGIC
    |=> O_FLAGS[BIT_Z] == ($past(I_ALU_B) == 8'h00))
    else $error("zero flag wrong");

  // Pointer aimed at itself reads back its own address
  port_redirect_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_RD && via_port && mptr_reg == ADDR_MPTR |=> O_RDATA == ADDR_MPTR)
    else $error("indirect read not redirected");

  // Direct pointer write lands
  mptr_write_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_WR && I_ADDR == ADDR_MPTR |=> mptr_reg == $past(I_WDATA))
    else $error("pointer write lost");

  // General RAM write lands at its word
  gp_write_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_WR && is_gp(eff_addr) |=> ram_mem[$past(gp_idx)] == $past(I_WDATA))
    else $error("general RAM write lost");

  // Nothing is decoded above the general area
  high_ram_zero_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_RD && eff_addr > ADDR_GP_LAST |=> O_RDATA == 8'h00)
    else $error("read above RAM not zero");

  // Logic result reaches the accumulator
  acc_alu_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_ALU_VALID && I_ALU_OP == CSF_OP_LOGIC |=> O_ACC == $past(I_ALU_B))
    else $error("accumulator missed ALU result");

  // Plain load reaches the accumulator when no ALU op competes
  acc_load_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_ACC_LOAD && !I_ALU_VALID |=> O_ACC == $past(I_WDATA))
    else $error("accumulator load lost");

  // Table pointer write goes out to the fetch unit
  tbl_ptr_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_WR && I_ADDR == ADDR_TBL_PTR |=> O_TBL_PTR == $past(I_WDATA))
    else $error("table pointer write lost");

  // Table high byte moves only on a fetch
  tbl_ro_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    !I_TBL_VALID |=> $stable(tbl_high_reg))
    else $error("table high byte changed by bus");

  // Arithmetic flags take a bus write when no ALU op competes
  arith_write_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_WR && I_ADDR == ADDR_FLAGS && !I_ALU_VALID
    |=> O_FLAGS[3:0] == $past(I_WDATA[3:0]))
    else $error("flag write lost");

  // Signed wrap on add: like signs in, other sign out
  ov_add_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_ALU_VALID && I_ALU_OP == CSF_OP_ADD |=> O_FLAGS[BIT_OV] ==
    ($past(acc_reg[7]) == $past(I_ALU_B[7]) && $past(acc_reg[7]) != O_ACC[7]))
    else $error("signed wrap flag wrong");

  // Zero on subtract exactly when operands match
  zero_sub_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_ALU_VALID && I_ALU_OP == CSF_OP_SUB
    |=> O_FLAGS[BIT_Z] == ($past(acc_reg) == $past(I_ALU_B)))
    else $error("zero flag wrong on subtract");

  // Nibble carry on add: low nibble wrapped below its start
  half_add_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_ALU_VALID && I_ALU_OP == CSF_OP_ADD
    |=> O_FLAGS[BIT_AC] == (O_ACC[3:0] < $past(acc_reg[3:0])))
    else $error("half carry flag wrong");

  // Carry on add: result wrapped below the first operand
  carry_add_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_ALU_VALID && I_ALU_OP == CSF_OP_ADD
    |=> O_FLAGS[BIT_C] == (O_ACC < $past(acc_reg)))
    else $error("carry flag wrong on add");

  // Left rotate moves bit 7 into carry and carry into bit 0
  rot_carry_a: assert property (@(posedge I_CLOCK) disable iff (I_SRST)
    I_ALU_VALID && I_ALU_OP == CSF_OP_RLC
    |=> O_FLAGS[BIT_C] == $past(acc_reg[7])
    && O_ACC[0] == $past(O_FLAGS[BIT_C]))
    else $error("rotate carry wrong");
endmodule // csf_core_regs

// ===== sim/csf_cpu_model.sv
// Behavioural CPU execution unit that issues requests to the core registers
`timescale 1ns/1ps
module csf_cpu_model
  import csf_pkg::*;
(
  input  wire logic       i_clk,   // System clock
  output logic      [7:0] o_addr,  // Data address
  output logic            o_rd,    // Read strobe
  output logic            o_wr,    // Write strobe
  output logic      [7:0] o_wdata, // Write data, also ALU operand
  output logic            o_alu,   // ALU valid
  output csf_op_e         o_op,    // ALU class
  output logic            o_ld,    // Accumulator load
  output logic            o_tbl,   // Table word valid
  output logic [TBL_WORD_W-1:0] o_word, // Table word
  output logic      [2:0] o_sys    // {expiry, kick, halt}
);
  logic ptr_loaded;
  int   order_errs;

  // Idle before the first request
  initial begin
    {o_rd, o_wr, o_alu, o_ld, o_tbl, o_sys} = 8'h00;
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_op = CSF_OP_ADD;
    o_word = '0;
    ptr_loaded = 1'b0;
    order_errs = 0;
  end

  // One request per call, held over exactly one edge, then dropped
  // Flags are never pushed here; callers save them when needed
  task automatic beat(input logic [7:0] ctl, input logic [7:0] a,
                      input logic [7:0] d, input csf_op_e op,
                      input logic [TBL_WORD_W-1:0] w);
    if (ctl[6] && a == ADDR_TBL_PTR)
      ptr_loaded = 1'b1;
    if (ctl[3] && !ptr_loaded)
      order_errs++;
    @(posedge i_clk);
    {o_rd, o_wr, o_alu, o_ld, o_tbl, o_sys} <= ctl;
    o_addr <= a;
    o_wdata <= d;
    o_op <= op;
    o_word <= w;
    @(posedge i_clk);
    {o_rd, o_wr, o_alu, o_ld, o_tbl, o_sys} <= 8'h00;
    #1;
  endtask
endmodule // csf_cpu_model

// ===== sim/csf_core_regs_tb.sv
// Self-checking bench for the core special function registers
`timescale 1ns/1ps
module csf_core_regs_tb;
  import csf_pkg::*;
  logic       clk, srst, rd, wr, alu, ld, tbl, jump, dummy;
  logic [7:0] addr, wdata, rdata, acc, tptr, tlow, flags, program_counter_low;
  logic [2:0] sys;
  logic [TBL_WORD_W-1:0] word;
  csf_op_e    op;
  int         bad_count = 0;
  int         tests_run = 0;

  csf_core_regs csf_core_regs_inst (
    .I_CLOCK(clk), .I_SRST(srst), .I_ADDR(addr), .I_RD(rd), .I_WR(wr),
    .I_WDATA(wdata), .I_ALU_VALID(alu), .I_ALU_OP(op), .I_ALU_B(wdata),
    .I_ACC_LOAD(ld), .I_TBL_VALID(tbl), .I_TBL_WORD(word),
    .I_WDT_EXPIRY(sys[2]), .I_DOG_KICK(sys[1]), .I_HALT(sys[0]),
    .O_RDATA(rdata), .O_ACC(acc), .O_TBL_PTR(tptr), .O_TBL_LOW(tlow),
    .O_FLAGS(flags), .O_JUMP(jump), .O_PC_LOW(program_counter_low), .O_DUMMY_CYCLE(dummy));

  csf_cpu_model csf_cpu_model_inst (
    .i_clk(clk), .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata),
    .o_alu(alu), .o_op(op), .o_ld(ld), .o_tbl(tbl), .o_word(word),
    .o_sys(sys));

  // Free-running 40 MHz clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Bus helpers; read data is registered on the take edge and checked 1 ns after it
  task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
    csf_cpu_model_inst.beat(8'h40, a, d, CSF_OP_ADD, '0);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    csf_cpu_model_inst.beat(8'h80, a, 8'h00, CSF_OP_ADD, '0);
    check(rdata, exp);
  endtask
  task automatic pulse(input logic [7:0] ctl, input logic [7:0] exp);
    csf_cpu_model_inst.beat(ctl, 8'h00, 8'h00, CSF_OP_ADD, '0);
    check(flags, exp);
  endtask
  // Load the accumulator, run one ALU op, compare result and flags
  task automatic alu_op(input logic [7:0] a, input csf_op_e o,
                        input logic [7:0] b, input logic [7:0] res,
                        input logic [3:0] nib);
    csf_cpu_model_inst.beat(8'h10, 8'h00, a, CSF_OP_ADD, '0);
    csf_cpu_model_inst.beat(8'h20, 8'h00, b, o, '0);
    check(acc, res);
    check(flags, {4'h0, nib});
  endtask

  task automatic t_memory();
    wr_b(ADDR_GP_FIRST, 8'ha5);
    wr_b(ADDR_GP_LAST, 8'h3c);
    wr_b(ADDR_MPTR, ADDR_GP_LAST);
    rd_chk(ADDR_MPTR, ADDR_GP_LAST);
    rd_chk(ADDR_INDIRECT, 8'h3c);
    wr_b(ADDR_INDIRECT, 8'h77);
    rd_chk(ADDR_GP_LAST, 8'h77);
    rd_chk(ADDR_GP_FIRST, 8'ha5);
    wr_b(ADDR_MPTR, 8'h00);
    wr_b(ADDR_INDIRECT, 8'h5a);
    rd_chk(ADDR_INDIRECT, 8'h00);
    wr_b(ADDR_GAP_FIRST, 8'hff);
    rd_chk(ADDR_GAP_FIRST, 8'h00);
    rd_chk(ADDR_SPC_LAST, 8'h00);
    wr_b(8'h60, 8'h99);
    rd_chk(8'h60, 8'h00);
  endtask

  task automatic t_jump_table();
    wr_b(ADDR_PCL, 8'h5b);
    check({6'h00, jump, dummy}, 8'h03);
    check(program_counter_low, 8'h5b);
    @(posedge clk);
    #1;
    check({6'h00, jump, dummy}, 8'h00);
    wr_b(ADDR_TBL_PTR, 8'h06);
    rd_chk(ADDR_TBL_PTR, 8'h06);
    check(tptr, 8'h06);
    csf_cpu_model_inst.beat(8'h08, 8'h00, 8'h00, CSF_OP_ADD, 14'h3f1a);
    check(tlow, 8'h1a);
    wr_b(ADDR_TBL_HIGH, 8'h00);
    rd_chk(ADDR_TBL_HIGH, 8'h3f);
    check(csf_cpu_model_inst.order_errs[7:0], 8'h00);
  endtask

  // Operands chosen to hit each flag in both directions
  task automatic t_alu();
    alu_op(8'hff, CSF_OP_ADD, 8'h01, 8'h00, 4'b0111);
    alu_op(8'h7f, CSF_OP_ADD, 8'h01, 8'h80, 4'b1010);
    alu_op(8'h05, CSF_OP_SUB, 8'h05, 8'h00, 4'b0111);
    alu_op(8'h00, CSF_OP_SUB, 8'h01, 8'hff, 4'b0000);
    alu_op(8'hff, CSF_OP_RLC, 8'h00, 8'hfe, 4'b0001);
    alu_op(8'hfe, CSF_OP_RRC, 8'h00, 8'hff, 4'b0000);
    alu_op(8'h12, CSF_OP_LOGIC, 8'h00, 8'h00, 4'b0100);
    rd_chk(ADDR_ACC, 8'h00);
    wr_b(ADDR_FLAGS, 8'hff);
    rd_chk(ADDR_FLAGS, 8'h0f);
  endtask

  task automatic t_system_flags();
    pulse(8'h01, 8'h1f);
    pulse(8'h04, 8'h3f);
    wr_b(ADDR_FLAGS, 8'h00);
    check(flags, 8'h30);
    pulse(8'h01, 8'h10);
    pulse(8'h04, 8'h30);
    pulse(8'h02, 8'h00);
  endtask

  // Mid-run reset: system flags return to zero, pointer restarts
  task automatic t_reset();
    pulse(8'h01, 8'h10);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    check({6'h00, flags[5:4]}, 8'h00);
    check({6'h00, flags[7:6]}, 8'h00);
    rd_chk(ADDR_MPTR, 8'h00);
  endtask

  // Main sequence: reset held for four cycles, then each scenario
  initial begin
    srst = 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    #1;
    check({6'h00, flags[5:4]}, 8'h00);
    t_memory();
    t_jump_table();
    t_alu();
    t_system_flags();
    t_reset();
    close_out();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule // csf_core_regs_tb
